// ==== epi_pkg.sv ====
package epi_pkg;

	// Register offsets on the plain register port.
	localparam logic [7:0] REG_PC_MASK_LOW  = 8'h32;
	localparam logic [7:0] REG_PC_MASK_HIGH = 8'h33;
	localparam logic [7:0] REG_MCU_CONTROL  = 8'h35;
	localparam logic [7:0] REG_IRQ_FLAGS    = 8'h3a;
	localparam logic [7:0] REG_IRQ_ENABLE   = 8'h3b;

	// Field positions shared by the enable mask and the flag register.
	localparam int BIT_EXT_PIN    = 6;
	localparam int BIT_GROUP_HIGH = 5;
	localparam int BIT_GROUP_LOW  = 4;
	localparam logic [7:0] IRQ_BITS_MASK = 8'h70;

	// Reset values.
	localparam logic [7:0] RST_IRQ_ENABLE  = 8'h00;
	localparam logic [7:0] RST_MCU_CONTROL = 8'h00;
	localparam logic [7:0] RST_PC_MASK     = 8'h00;
	localparam logic [2:0] RST_FLAGS       = 3'h0;
	localparam logic [7:0] RST_RDATA       = 8'h00;

	// Vector addresses fetched by the core.
	localparam logic [15:0] VEC_NONE       = 16'h0000;
	localparam logic [15:0] VEC_EXT_PIN    = 16'h0001;
	localparam logic [15:0] VEC_GROUP_LOW  = 16'h0002;
	localparam logic [15:0] VEC_GROUP_HIGH = 16'h0003;

	// Sample counter: edges are trusted once the pin history is valid.
	localparam logic [1:0] PRIME_DONE = 2'h3;
	localparam logic [1:0] PRIME_STEP = 2'h1;

	// Sense selection in mcu_control bits 1:0, in encoding order.
	typedef enum logic [1:0] {
		EPI_SENSE_LOW,
		EPI_SENSE_ANY,
		EPI_SENSE_FALL,
		EPI_SENSE_RISE
	} epi_sense_t;

endpackage : epi_pkg

// ==== epi_top.sv ====
`timescale 1ns/1ps
module epi_top (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 nrst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [7:0]           reg_rdata,
	// Pins
	input  wire logic [15:0]          pin_change_input,
	input  wire logic                 ext_irq_pin,
	// Core side
	input  wire logic                 core_irq_enable,
	input  wire logic                 irq_ack,
	output logic                      irq_req,
	output logic      [15:0]          irq_vector,
	output logic                      wake_req
);
	import epi_pkg::*;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	logic [7:0]  irq_enable_mask;
	logic [7:0]  mcu_control;
	logic [7:0]  pin_change_mask_low;
	logic [7:0]  pin_change_mask_high;
	logic        ext_pin_flag;
	logic        group_low_flag;
	logic        group_high_flag;
	logic [16:0] pin_meta;
	logic [16:0] pin_sync;
	logic [16:0] pin_prev;
	logic [1:0]  prime_cnt;

	// Register decode.
	wire wr_enable = reg_wr && hit(reg_addr, REG_IRQ_ENABLE);
	wire wr_flags  = reg_wr && hit(reg_addr, REG_IRQ_FLAGS);
	wire wr_mcu    = reg_wr && hit(reg_addr, REG_MCU_CONTROL);
	wire wr_mlow   = reg_wr && hit(reg_addr, REG_PC_MASK_LOW);
	wire wr_mhigh  = reg_wr && hit(reg_addr, REG_PC_MASK_HIGH);

	wire epi_sense_t sense = epi_sense_t'(mcu_control[1:0]);
	wire ext_en  = irq_enable_mask[BIT_EXT_PIN];
	wire high_en = irq_enable_mask[BIT_GROUP_HIGH];
	wire low_en  = irq_enable_mask[BIT_GROUP_LOW];
	wire primed  = (prime_cnt == PRIME_DONE);

	// The pins are sampled at the pad whatever their direction.
	wire [16:0] pin_raw = {ext_irq_pin, pin_change_input};

	// Edge detection works only on synchronised samples.
	wire [16:0] pin_toggle  = primed ? (pin_sync ^ pin_prev) : 17'h00000;
	wire        ext_sync    = pin_sync[16];
	wire        ext_rise    = pin_toggle[16] && ext_sync;
	wire        ext_fall    = pin_toggle[16] && !ext_sync;
	wire [7:0]  low_active  = pin_change_mask_low & {8{low_en}};
	wire [7:0]  high_active = pin_change_mask_high & {8{high_en}};
	wire        low_change  = |(pin_toggle[7:0] & low_active);
	wire        high_change = |(pin_toggle[15:8] & high_active);

	// Sense decode for the dedicated pin.
	logic ext_edge;
	always_comb begin
		unique case (sense)
			EPI_SENSE_LOW:  ext_edge = 1'b0;
			EPI_SENSE_ANY:  ext_edge = pin_toggle[16];
			EPI_SENSE_FALL: ext_edge = ext_fall;
			EPI_SENSE_RISE: ext_edge = ext_rise;
		endcase
	end

	// The level request follows the synchronised pin, so a low that vanishes
	// before the core is running again simply leaves nothing pending.
	wire ext_level  = (sense == EPI_SENSE_LOW) && !ext_sync && primed;
	wire gie        = core_irq_enable;
	wire want_ext   = gie && ext_en && (ext_pin_flag || ext_level);
	wire want_low   = gie && low_en && group_low_flag;
	wire want_high  = gie && high_en && group_high_flag;

	// Fixed priority by vector address.
	assign irq_req    = want_ext || want_low || want_high;
	assign irq_vector = want_ext ? VEC_EXT_PIN :
	                    want_low ? VEC_GROUP_LOW :
	                    want_high ? VEC_GROUP_HIGH : VEC_NONE;

	// Flag clears: write one, or the core taking the presented vector.
	wire ack_ext  = irq_ack && (irq_vector == VEC_EXT_PIN);
	wire ack_low  = irq_ack && (irq_vector == VEC_GROUP_LOW);
	wire ack_high = irq_ack && (irq_vector == VEC_GROUP_HIGH);
	wire clr_ext  = ack_ext || (wr_flags && reg_wdata[BIT_EXT_PIN]);
	wire clr_low  = ack_low || (wr_flags && reg_wdata[BIT_GROUP_LOW]);
	wire clr_high = ack_high || (wr_flags && reg_wdata[BIT_GROUP_HIGH]);

	// A set in the same cycle as a clear wins, so no event is lost.
	wire next_ext_pin_flag    = (sense != EPI_SENSE_LOW) &&
	                            (ext_edge || (ext_pin_flag && !clr_ext));
	wire next_group_low_flag  = low_change || (group_low_flag && !clr_low);
	wire next_group_high_flag = high_change || (group_high_flag && !clr_high);

	// Pin-change wake is a purely combinational compare of the pad against the last
	// synchronised value, so it asserts even with every clock stopped.
	// The cost is that glitches shorter than the minimum width may wake
	// the part without leaving a flag behind.
	wire wake_pc  = |((pin_change_input ^ pin_sync[15:0]) &
	                  {high_active, low_active});
	// Only the selected condition wakes, so an edge of the wrong direction
	// cannot start the clocks and then leave nothing pending.
	logic wake_ext_cond;
	always_comb begin
		unique case (sense)
			EPI_SENSE_LOW:  wake_ext_cond = !ext_irq_pin;
			EPI_SENSE_ANY:  wake_ext_cond = (ext_irq_pin != ext_sync);
			EPI_SENSE_FALL: wake_ext_cond = !ext_irq_pin && ext_sync;
			EPI_SENSE_RISE: wake_ext_cond = ext_irq_pin && !ext_sync;
		endcase
	end
	wire wake_ext = ext_en && wake_ext_cond;
	assign wake_req = primed && (wake_pc || wake_ext);

	// Read mux; reserved bits of the enable and flag registers come back zero.
	wire [7:0] flags_view = {1'b0, ext_pin_flag, group_high_flag, group_low_flag, 4'h0};
	wire [7:0] next_rdata =
		!reg_rd                                    ? RST_RDATA :
		hit(reg_addr, REG_IRQ_ENABLE)              ? irq_enable_mask :
		hit(reg_addr, REG_IRQ_FLAGS)               ? flags_view :
		hit(reg_addr, REG_MCU_CONTROL)             ? mcu_control :
		hit(reg_addr, REG_PC_MASK_LOW)             ? pin_change_mask_low :
		hit(reg_addr, REG_PC_MASK_HIGH)            ? pin_change_mask_high : RST_RDATA;

	// Two-flop synchroniser plus history; pin_meta feeds only pin_sync.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pin_meta  <= 17'h00000;
			pin_sync  <= 17'h00000;
			pin_prev  <= 17'h00000;
			prime_cnt <= 2'h0;
		end else begin
			pin_meta  <= pin_raw;
			pin_sync  <= pin_meta;
			pin_prev  <= pin_sync;
			prime_cnt <= primed ? prime_cnt : prime_cnt + PRIME_STEP;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			irq_enable_mask      <= RST_IRQ_ENABLE;
			mcu_control          <= RST_MCU_CONTROL;
			pin_change_mask_low  <= RST_PC_MASK;
			pin_change_mask_high <= RST_PC_MASK;
		end else begin
			if (wr_enable) begin
				irq_enable_mask <= reg_wdata & IRQ_BITS_MASK;
			end
			if (wr_mcu) begin
				mcu_control <= reg_wdata;
			end
			if (wr_mlow) begin
				pin_change_mask_low <= reg_wdata;
			end
			if (wr_mhigh) begin
				pin_change_mask_high <= reg_wdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{ext_pin_flag, group_high_flag, group_low_flag} <= RST_FLAGS;
			reg_rdata <= RST_RDATA;
		end else begin
			ext_pin_flag    <= next_ext_pin_flag;
			group_high_flag <= next_group_high_flag;
			group_low_flag  <= next_group_low_flag;
			reg_rdata       <= next_rdata;
		end
	end

	// Checks.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_level_hold;
		gie && ext_en && ext_level |-> irq_req && (irq_vector == VEC_EXT_PIN);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level request missing");

	property p_level_no_flag;
		sense == EPI_SENSE_LOW |=> !ext_pin_flag;
	endproperty
	a_level_no_flag: assert property (p_level_no_flag) else $error("flag set in level mode");

	property p_low_toggle;
		primed && low_en && |((pin_sync[7:0] ^ pin_prev[7:0]) & pin_change_mask_low)
		|=> group_low_flag;
	endproperty
	a_low_toggle: assert property (p_low_toggle) else $error("low group change missed");

	property p_high_toggle;
		primed && high_en && |((pin_sync[15:8] ^ pin_prev[15:8]) & pin_change_mask_high)
		|=> group_high_flag;
	endproperty
	a_high_toggle: assert property (p_high_toggle) else $error("high group change missed");

	property p_mask_gate;
		!low_en && !group_low_flag |=> !group_low_flag;
	endproperty
	a_mask_gate: assert property (p_mask_gate) else $error("disabled group set flag");

	property p_w1c;
		wr_flags && reg_wdata[BIT_GROUP_HIGH] && !high_change |=> !group_high_flag;
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear");

	property p_gie;
		!core_irq_enable |-> !irq_req;
	endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");

	property p_prio;
		irq_req && want_low && want_high && !want_ext |-> irq_vector == VEC_GROUP_LOW;
	endproperty
	a_prio: assert property (p_prio) else $error("wrong vector priority");

	property p_rsvd;
		reg_rd && (hit(reg_addr, REG_IRQ_ENABLE) || hit(reg_addr, REG_IRQ_FLAGS))
		|=> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

	property p_ext_edge;
		primed && sense == EPI_SENSE_RISE && $rose(pin_sync[16]) |=> ext_pin_flag;
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("rising edge not flagged");

	property p_wake;
		primed && low_en && |((pin_change_input[7:0] ^ pin_sync[7:0]) & pin_change_mask_low)
		|-> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("pin change gave no wake");

	property p_ext_fall;
		primed && sense == EPI_SENSE_FALL && $fell(pin_sync[16]) |=> ext_pin_flag;
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("fall not flagged");

	property p_ext_any;
		primed && sense == EPI_SENSE_ANY && (pin_sync[16] != pin_prev[16]) |=> ext_pin_flag;
	endproperty
	a_ext_any: assert property (p_ext_any) else $error("change not flagged");

	property p_ext_w1c;
		wr_flags && reg_wdata[BIT_EXT_PIN] && !ext_edge |=> !ext_pin_flag;
	endproperty
	a_ext_w1c: assert property (p_ext_w1c) else $error("pin flag not cleared");

	property p_ack_low;
		irq_ack && irq_vector == VEC_GROUP_LOW && !low_change |=> !group_low_flag;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("low ack kept flag");

	property p_ack_high;
		irq_ack && irq_vector == VEC_GROUP_HIGH && !high_change |=> !group_high_flag;
	endproperty
	a_ack_high: assert property (p_ack_high) else $error("high ack kept flag");

	property p_high_gate;
		!high_en && !group_high_flag |=> !group_high_flag;
	endproperty
	a_high_gate: assert property (p_high_gate) else $error("high group set flag");

	property p_ext_gate;
		!ext_en |-> irq_vector != VEC_EXT_PIN;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("pin vector while off");

	property p_ext_first;
		want_ext |-> irq_vector == VEC_EXT_PIN;
	endproperty
	a_ext_first: assert property (p_ext_first) else $error("pin not first");

	property p_wake_level;
		primed && ext_en && sense == EPI_SENSE_LOW && !ext_irq_pin |-> wake_req;
	endproperty
	a_wake_level: assert property (p_wake_level) else $error("low gave no wake");

	c_ext_vec: cover property (irq_req && irq_vector == VEC_EXT_PIN && irq_ack);
	c_low_vec: cover property (irq_req && irq_vector == VEC_GROUP_LOW && irq_ack);
	c_high_vec: cover property (irq_req && irq_vector == VEC_GROUP_HIGH && irq_ack);
	c_set_clr: cover property (low_change && clr_low);
	c_level_wake: cover property (wake_req && sense == EPI_SENSE_LOW);

endmodule : epi_top

// ==== epi_src_model.sv ====
`timescale 1ns/1ps
// Stands in for the outside sources wired to the interrupt pins.
module epi_src_model (
	// Clock
	input  wire logic        ref_clk,
	// Pins
	output logic      [15:0] pc_pins,
	output logic             ext_pin
);
	initial begin
		pc_pins = 16'h0000;
		ext_pin = 1'b1;
	end

	// Callers hold every level for several clocks, far wider than the minimum pulse.
	task automatic toggle_pc(input int idx);
		@(posedge ref_clk);
		pc_pins[idx] <= ~pc_pins[idx];
	endtask : toggle_pc

	// A low level stays until released, beyond any instruction in flight.
	task automatic drive_ext(input logic level);
		@(posedge ref_clk);
		ext_pin <= level;
	endtask : drive_ext
endmodule : epi_src_model

// ==== epi_top_tb.sv ====
`timescale 1ns/1ps
module epi_top_tb;
	import epi_pkg::*;
	logic        ref_clk, nrst, reg_wr, reg_rd, core_irq_enable, irq_ack;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [15:0] pcin, irq_vector;
	logic        ext, irq_req, wake_req;
	int          n_fail, checks_done;

	epi_src_model src (.ref_clk(ref_clk), .pc_pins(pcin), .ext_pin(ext));
	epi_top dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_change_input(pcin),
		.ext_irq_pin(ext), .core_irq_enable(core_irq_enable), .irq_ack(irq_ack),
		.irq_req(irq_req), .irq_vector(irq_vector), .wake_req(wake_req));

	always #2.5 ref_clk = ~ref_clk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_reg

	task automatic chk_irq(input string nm, input logic e_req, input logic [15:0] e_vec);
		checks_done++;
		if ({irq_req, irq_vector} !== {e_req, e_vec}) begin
			n_fail++;
			$display("mismatch %s expected %b/%h seen %b/%h", nm, e_req, e_vec, irq_req, irq_vector);
		end
	endtask : chk_irq

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// Read data stand only in the cycle after the strobe, so they are taken just past that edge.
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk_reg(nm, e, reg_rdata);
	endtask : rd_chk

	task automatic ack();
		@(posedge ref_clk);
		irq_ack <= 1'b1;
		@(posedge ref_clk);
		irq_ack <= 1'b0;
		#1;
	endtask : ack

	task automatic t_regs();
		rd_chk("enable reset", REG_IRQ_ENABLE, 8'h00);
		reg_write(REG_IRQ_ENABLE, 8'hff);
		rd_chk("enable reserved", REG_IRQ_ENABLE, 8'h70);
		reg_write(REG_IRQ_FLAGS, 8'hff);
		rd_chk("flags reserved", REG_IRQ_FLAGS, 8'h00);
		reg_write(REG_IRQ_ENABLE, 8'h00);
		reg_write(REG_MCU_CONTROL, 8'ha6);
		rd_chk("mcu control", REG_MCU_CONTROL, 8'ha6);
		reg_write(REG_PC_MASK_HIGH, 8'h80);
		rd_chk("mask high", REG_PC_MASK_HIGH, 8'h80);
		rd_chk("unmapped", 8'h00, 8'h00);
		rd_chk("alias", 8'hfb, 8'h00);
		$display("test regs done");
	endtask : t_regs

	task automatic t_groups();
		core_irq_enable <= 1'b1;
		reg_write(REG_PC_MASK_LOW, 8'h01);
		reg_write(REG_IRQ_ENABLE, 8'h10);
		src.toggle_pc(1);
		src.toggle_pc(8);
		cyc(4);
		chk_irq("masked pins", 1'b0, VEC_NONE);
		src.toggle_pc(0);
		#1;
		chk_reg("wake", 8'h01, {7'h00, wake_req});
		cyc(4);
		chk_irq("low group", 1'b1, VEC_GROUP_LOW);
		core_irq_enable <= 1'b0;
		cyc(1);
		chk_irq("global off", 1'b0, VEC_NONE);
		rd_chk("low flag", REG_IRQ_FLAGS, 8'h10);
		reg_write(REG_IRQ_FLAGS, 8'h10);
		rd_chk("low flag cleared", REG_IRQ_FLAGS, 8'h00);
		reg_write(REG_IRQ_ENABLE, 8'h20);
		src.toggle_pc(0);
		src.toggle_pc(15);
		core_irq_enable <= 1'b1;
		cyc(4);
		chk_irq("high group", 1'b1, VEC_GROUP_HIGH);
		rd_chk("group gate", REG_IRQ_FLAGS, 8'h20);
		ack();
		chk_irq("high acked", 1'b0, VEC_NONE);
		$display("test groups done");
	endtask : t_groups

	task automatic t_ext();
		epi_sense_t m;
		logic       fall, rise;
		reg_write(REG_IRQ_ENABLE, 8'h40);
		for (int i = 1; i < 4; i++) begin
			m    = epi_sense_t'(i);
			fall = (m != EPI_SENSE_RISE);
			rise = (m != EPI_SENSE_FALL);
			reg_write(REG_MCU_CONTROL, {6'h00, m});
			reg_write(REG_IRQ_FLAGS, 8'h40);
			src.drive_ext(1'b0);
			#1;
			chk_reg("ext wake", {7'h00, fall}, {7'h00, wake_req});
			cyc(4);
			chk_irq("ext fall", fall, fall ? VEC_EXT_PIN : VEC_NONE);
			reg_write(REG_IRQ_FLAGS, 8'h40);
			cyc(1);
			chk_irq("ext cleared", 1'b0, VEC_NONE);
			src.drive_ext(1'b1);
			cyc(4);
			chk_irq("ext rise", rise, rise ? VEC_EXT_PIN : VEC_NONE);
			reg_write(REG_IRQ_FLAGS, 8'h40);
		end
		reg_write(REG_MCU_CONTROL, 8'h00);
		src.drive_ext(1'b0);
		cyc(3);
		chk_irq("level", 1'b1, VEC_EXT_PIN);
		rd_chk("level flag", REG_IRQ_FLAGS, 8'h00);
		ack();
		chk_irq("level held", 1'b1, VEC_EXT_PIN);
		src.drive_ext(1'b1);
		cyc(3);
		chk_irq("level gone", 1'b0, VEC_NONE);
		$display("test ext done");
	endtask : t_ext

	task automatic t_prio();
		reg_write(REG_MCU_CONTROL, {6'h00, EPI_SENSE_FALL});
		reg_write(REG_IRQ_ENABLE, 8'h70);
		src.toggle_pc(15);
		src.drive_ext(1'b0);
		src.toggle_pc(0);
		cyc(4);
		chk_irq("prio first", 1'b1, VEC_EXT_PIN);
		ack();
		chk_irq("prio second", 1'b1, VEC_GROUP_LOW);
		ack();
		chk_irq("prio third", 1'b1, VEC_GROUP_HIGH);
		ack();
		chk_irq("prio none", 1'b0, VEC_NONE);
		src.drive_ext(1'b1);
		$display("test prio done");
	endtask : t_prio

	// Every pad alone, with only its own mask bit set, must land in its own group.
	task automatic t_pins();
		logic [7:0] bit_sel;
		reg_write(REG_IRQ_ENABLE, 8'h30);
		for (int i = 0; i < 16; i++) begin
			bit_sel = 8'h01 << i[2:0];
			reg_write(REG_PC_MASK_LOW, (i < 8) ? bit_sel : 8'h00);
			reg_write(REG_PC_MASK_HIGH, (i < 8) ? 8'h00 : bit_sel);
			src.toggle_pc(i);
			cyc(4);
			chk_irq("pin irq", 1'b1, (i < 8) ? VEC_GROUP_LOW : VEC_GROUP_HIGH);
			rd_chk("pin", REG_IRQ_FLAGS, (i < 8) ? 8'h10 : 8'h20);
			reg_write(REG_IRQ_FLAGS, 8'h30);
		end
		$display("test pins done");
	endtask : t_pins

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end

	initial begin
		ref_clk         = 1'b0;
		nrst            = 1'b0;
		reg_addr        = 8'h00;
		reg_wdata       = 8'h00;
		reg_wr          = 1'b0;
		reg_rd          = 1'b0;
		core_irq_enable = 1'b0;
		irq_ack         = 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		cyc(4);
		chk_irq("after reset", 1'b0, VEC_NONE);
		t_regs();
		t_groups();
		t_ext();
		t_prio();
		t_pins();
		wrap_up();
	end
endmodule : epi_top_tb
